//--- design/dcsp_if.sv
// Purpose: four-wire link between controller and one target
// Assumes: targets are chained by the bench, sdo to next sdi
// Notes: no clocking block
`timescale 1ns/1ps
`default_nettype none
interface dcsp_if;
	logic sclk;
	logic csN;
	logic sdi;
	logic sdo;
	modport tgt (input sclk, input csN, input sdi, output sdo);
	modport ctl (output sclk, output csN, output sdi, input sdo);
endinterface
`default_nettype wire

//--- design/dcsp_master.sv
// Purpose: controller end, drives a chain of targets
// Assumes: sclk derived from ref_clk by a divider
// Notes: one frame word per target, first word reaches the last target
`timescale 1ns/1ps
`default_nettype none
`include "dcsp_regs.svh"
module dcsp_master #(
	parameter int NDEV = 3,
	parameter int HALF = `DCSP_HALF_CYC,
	parameter int GAP = `DCSP_GAP_CYC
) (
	// link
	dcsp_if.ctl lnk,
	// clock and reset
	input wire logic ref_clk,
	input wire logic rstn,
	// user request
	input wire logic start,
	input wire logic [16*NDEV-1:0] txBits,
	// user answer
	output logic busy,
	output logic done,
	output logic [16*NDEV-1:0] rxBits
);
	import dcsp_pkg::*;

	localparam int TOTAL = 16 * NDEV;
	localparam int BW = $clog2(TOTAL + 1);
	localparam int TW = $clog2(HALF + GAP + 1);

	dcsp_state_e state;
	logic [TW-1:0] tick;
	logic [BW-1:0] bitsLeft;
	logic [TOTAL-1:0] txSh;
	logic sdoLvl;
	logic sclkOut;
	logic csOut;
	logic sdiOut;

	dcsp_sync #(.RST_VAL(1'b0)) u_sdoSync (
		.clk(ref_clk),
		.rstn(rstn),
		.din(lnk.sdo),
		.dout(sdoLvl)
	);

	assign lnk.sclk = sclkOut;
	assign lnk.csN = csOut;
	assign lnk.sdi = sdiOut;

	// sequencer: idle, lead, bit halves, tail, gap
	always_ff @(posedge ref_clk) begin
		if (!rstn) begin
			state <= DCSP_IDLE;
			tick <= '0;
			bitsLeft <= '0;
			txSh <= '0;
			rxBits <= '0;
			sclkOut <= 1'b0;
			csOut <= 1'b1;
			sdiOut <= 1'b0;
			busy <= 1'b0;
			done <= 1'b0;
		end else begin
			done <= 1'b0;
			if (tick != '0) begin
				tick <= tick - TW'(1);
			end
			unique case (state)
				DCSP_IDLE: begin
					if (start) begin
						busy <= 1'b1;
						csOut <= 1'b0;
						txSh <= txBits;
						bitsLeft <= BW'(TOTAL);
						tick <= TW'(HALF - 1);
						state <= DCSP_LEAD;
					end
				end
				DCSP_LEAD, DCSP_LOW: begin
					sdiOut <= txSh[TOTAL-1];
					if (tick == '0) begin
						sclkOut <= 1'b1;
						tick <= TW'(HALF - 1);
						state <= DCSP_HIGH;
					end
				end
				DCSP_HIGH: begin
					if (tick == '0) begin
						rxBits <= {rxBits[TOTAL-2:0], sdoLvl};
						txSh <= {txSh[TOTAL-2:0], 1'b1};
						sclkOut <= 1'b0;
						bitsLeft <= bitsLeft - BW'(1);
						tick <= TW'(HALF - 1);
						state <= (bitsLeft == BW'(1)) ? DCSP_TAIL : DCSP_LOW;
					end
				end
				DCSP_TAIL: begin
					if (tick == '0) begin
						csOut <= 1'b1;
						tick <= TW'(GAP - 1);
						state <= DCSP_GAP;
					end
				end
				DCSP_GAP: begin
					if (tick == '0) begin
						busy <= 1'b0;
						done <= 1'b1;
						state <= DCSP_IDLE;
					end
				end
			endcase
		end
	end
endmodule // dcsp_master
`default_nettype wire

//--- design/dcsp_pkg.sv
// Purpose: types shared by both ends of the serial register port
// Assumes: frame layout of 7-bit address, read flag, 8-bit data
// Notes: constants live in dcsp_regs.svh
package dcsp_pkg;
	typedef logic [6:0] dcsp_addr_t;
	typedef logic [7:0] dcsp_data_t;
	typedef logic [15:0] dcsp_word_t;
	typedef struct packed {
		dcsp_addr_t addr;
		logic rd;
		dcsp_data_t data;
	} dcsp_frame_s;
	typedef enum {
		DCSP_IDLE,
		DCSP_LEAD,
		DCSP_LOW,
		DCSP_HIGH,
		DCSP_TAIL,
		DCSP_GAP
	} dcsp_state_e;
endpackage

//--- design/dcsp_regs.svh
// Purpose: constants of the daisy-chain serial register port
// Assumes: one 16-bit frame per target, sent msb first
// Notes: included by bare name
`ifndef DCSP_REGS_SVH
`define DCSP_REGS_SVH
`define DCSP_FRAME_BITS 16
`define DCSP_CNT_W 5
`define DCSP_ADDR_MSB 15
`define DCSP_ADDR_LSB 9
`define DCSP_RW_BIT 8
`define DCSP_DATA_MSB 7
`define DCSP_DATA_LSB 0
`define DCSP_RESP_IDLE 16'h0000
`define DCSP_RESP_PAD 8'h00
`define DCSP_NOP_WORD 16'hFFFF
`define DCSP_REG_RST 8'h00
`define DCSP_REF_MHZ 100
`define DCSP_SCLK_NS 100
`define DCSP_HALF_CYC ((`DCSP_SCLK_NS * `DCSP_REF_MHZ / 1000) / 2)
`define DCSP_GAP_NS 80
`define DCSP_GAP_CYC ((`DCSP_GAP_NS * `DCSP_REF_MHZ + 999) / 1000)
`endif

//--- design/dcsp_sync.sv
// Purpose: three-stage synchroniser with agreement filter
// Assumes: input is asynchronous to clk
// Notes: output moves only when stages two and three agree
`timescale 1ns/1ps
`default_nettype none
module dcsp_sync #(
	parameter logic RST_VAL = 1'b0
) (
	// clock and reset
	input wire logic clk,
	input wire logic rstn,
	// level in and out
	input wire logic din,
	output logic dout
);
	logic s1;
	logic s2;
	logic s3;

	always_ff @(posedge clk) begin
		if (!rstn) begin
			s1 <= RST_VAL;
			s2 <= RST_VAL;
			s3 <= RST_VAL;
		end else begin
			s1 <= din;
			s2 <= s1;
			s3 <= s2;
		end
	end

	always_ff @(posedge clk) begin
		if (!rstn) begin
			dout <= RST_VAL;
		end else if (s2 == s3) begin
			dout <= s3;
		end
	end
endmodule // dcsp_sync
`default_nettype wire

//--- design/dcsp_target.sv
// Purpose: target end of the chained serial register port
// Assumes: link logic on sclk; register file on ref_clk
// Notes: captured frame is held still while csN is high; response word is reloaded once after csN rises
`timescale 1ns/1ps
`default_nettype none
`include "dcsp_regs.svh"
module dcsp_target #(
	parameter int ADDR_W = 7
) (
	// link
	dcsp_if.tgt lnk,
	// clock and reset
	input wire logic ref_clk,
	input wire logic rstn,
	// command report
	output logic cmdValid,
	output logic cmdRead,
	output dcsp_pkg::dcsp_addr_t cmdAddr,
	output dcsp_pkg::dcsp_data_t cmdData,
	output logic frameDrop,
	// register peek
	input wire dcsp_pkg::dcsp_addr_t peekAddr,
	output dcsp_pkg::dcsp_data_t peekData
);
	import dcsp_pkg::*;

	localparam int DEPTH = 1 << ADDR_W;
	localparam int CNT_W = `DCSP_CNT_W;
	localparam logic [CNT_W-1:0] LAST_BIT = CNT_W'(`DCSP_FRAME_BITS - 1);
	localparam logic [CNT_W-1:0] FULL_CNT = CNT_W'(`DCSP_FRAME_BITS);

	// link side state
	logic [`DCSP_CNT_W-1:0] bitCnt;
	dcsp_word_t shiftReg;
	logic frameTgl;
	logic fellSeen;
	logic outBit;
	// ref side state
	logic linkClr;
	dcsp_word_t respWord;
	logic csLvl;
	logic csPrev;
	logic tglLvl;
	logic seenTgl;
	dcsp_data_t regFile [DEPTH];
	dcsp_frame_s frame;
	logic csRise;

	function automatic dcsp_frame_s split(input dcsp_word_t w);
		dcsp_frame_s f;
		f.addr = w[`DCSP_ADDR_MSB:`DCSP_ADDR_LSB];
		f.rd = w[`DCSP_RW_BIT];
		f.data = w[`DCSP_DATA_MSB:`DCSP_DATA_LSB];
		return f;
	endfunction

	// bit counter, cleared while deselected
	always_ff @(posedge lnk.sclk or posedge lnk.csN) begin
		if (lnk.csN) begin
			bitCnt <= '0;
		end else if (bitCnt != FULL_CNT) begin
			bitCnt <= bitCnt + CNT_W'(1);
		end
	end

	// shift register, response loaded ahead of first bit
	always_ff @(posedge lnk.sclk) begin
		if (!lnk.csN) begin
			if (bitCnt == '0) begin
				shiftReg <= {respWord[`DCSP_FRAME_BITS-2:0], lnk.sdi};
			end else begin
				shiftReg <= {shiftReg[`DCSP_FRAME_BITS-2:0], lnk.sdi};
			end
		end
	end

	// completion toggle on the sixteenth bit
	always_ff @(posedge lnk.sclk or posedge linkClr) begin
		if (linkClr) begin
			frameTgl <= 1'b0;
		end else if (!lnk.csN && bitCnt == LAST_BIT) begin
			frameTgl <= ~frameTgl;
		end
	end

	// first falling edge of the frame seen
	always_ff @(negedge lnk.sclk or posedge lnk.csN) begin
		if (lnk.csN) begin
			fellSeen <= 1'b0;
		end else begin
			fellSeen <= 1'b1;
		end
	end

	// output bit moves on falling sclk
	always_ff @(negedge lnk.sclk) begin
		if (!lnk.csN) begin
			outBit <= shiftReg[`DCSP_FRAME_BITS-1];
		end
	end

	// sdo low when deselected, msb first otherwise
	assign lnk.sdo = lnk.csN ? 1'b0 : (fellSeen ? outBit : respWord[`DCSP_FRAME_BITS-1]);

	// link reset driven from the ref side
	always_ff @(posedge ref_clk) begin
		linkClr <= !rstn;
	end

	// crossings
	dcsp_sync #(.RST_VAL(1'b1)) u_csSync (
		.clk(ref_clk),
		.rstn(rstn),
		.din(lnk.csN),
		.dout(csLvl)
	);

	dcsp_sync #(.RST_VAL(1'b0)) u_tglSync (
		.clk(ref_clk),
		.rstn(rstn),
		.din(frameTgl),
		.dout(tglLvl)
	);

	always_ff @(posedge ref_clk) begin
		if (!rstn) begin
			csPrev <= 1'b1;
		end else begin
			csPrev <= csLvl;
		end
	end

	assign csRise = csLvl && !csPrev;
	assign frame = split(shiftReg);

	// frame acceptance
	always_ff @(posedge ref_clk) begin
		if (!rstn) begin
			seenTgl <= 1'b0;
		end else if (csRise) begin
			seenTgl <= tglLvl;
		end
	end

	// register file writes
	always_ff @(posedge ref_clk) begin
		if (!rstn) begin
			for (int i = 0; i < DEPTH; i++) begin
				regFile[i] <= `DCSP_REG_RST;
			end
		end else if (csRise && tglLvl != seenTgl && !frame.rd) begin
			regFile[frame.addr[ADDR_W-1:0]] <= frame.data;
		end
	end

	// response for the next frame
	always_ff @(posedge ref_clk) begin
		if (!rstn) begin
			respWord <= `DCSP_RESP_IDLE;
		end else if (csRise) begin
			if (tglLvl != seenTgl && frame.rd) begin
				respWord <= {`DCSP_RESP_PAD, regFile[frame.addr[ADDR_W-1:0]]};
			end else begin
				respWord <= `DCSP_RESP_IDLE;
			end
		end
	end

	// command report
	always_ff @(posedge ref_clk) begin
		if (!rstn) begin
			cmdValid <= 1'b0;
			frameDrop <= 1'b0;
			cmdRead <= 1'b0;
			cmdAddr <= '0;
			cmdData <= '0;
		end else begin
			cmdValid <= csRise && tglLvl != seenTgl;
			frameDrop <= csRise && tglLvl == seenTgl;
			if (csRise && tglLvl != seenTgl) begin
				cmdRead <= frame.rd;
				cmdAddr <= frame.addr;
				cmdData <= frame.data;
			end
		end
	end

	// register peek
	always_ff @(posedge ref_clk) begin
		if (!rstn) begin
			peekData <= '0;
		end else begin
			peekData <= regFile[peekAddr[ADDR_W-1:0]];
		end
	end
endmodule // dcsp_target
`default_nettype wire

//--- testbench/daisy_chain_spi_register_port_test.sv
// Purpose: three chained targets under the controller, one target driven by hand
// Assumes: controller HALF 5, GAP 8
// Notes: first tx word lands in the last target
`timescale 1ns/1ps
`default_nettype none
module daisy_chain_spi_register_port_test;
	logic ref_clk = 1'b0;
	logic rstn = 1'b0;
	logic start = 1'b0;
	logic [47:0] txBits = '0;
	logic busy, done;
	logic [47:0] rxBits;
	logic [47:0] rowTx [5], rowRx [5];
	logic [15:0] cap;
	dcsp_pkg::dcsp_addr_t peekAddr = 7'h05;
	dcsp_pkg::dcsp_addr_t ca [4];
	dcsp_pkg::dcsp_data_t cd [4], pd [4];
	logic cv [4], cr [4], fd [4];
	int errCount = 0, numChecks = 0, nDrop = 0, nValid = 0, nChain = 0;
	dcsp_if m();
	dcsp_if t [3] ();
	dcsp_if r();
	always #5 ref_clk = ~ref_clk;
	dcsp_master #(.NDEV(3)) dcsp_master_i (.lnk(m), .ref_clk, .rstn, .start, .txBits, .busy,
		.done, .rxBits);
	for (genvar k = 0; k < 3; k++) begin : g
		assign t[k].sclk = m.sclk;
		assign t[k].csN = m.csN;
		if (k == 0) begin : h
			assign t[k].sdi = m.sdi;
		end else begin : h
			assign t[k].sdi = t[k-1].sdo;
		end
		dcsp_target dcsp_target_i (.lnk(t[k]), .ref_clk, .rstn, .cmdValid(cv[k]), .cmdRead(cr[k]),
			.cmdAddr(ca[k]), .cmdData(cd[k]), .frameDrop(fd[k]), .peekAddr, .peekData(pd[k]));
	end
	assign m.sdo = t[2].sdo;
	dcsp_target dcsp_target_i (.lnk(r), .ref_clk, .rstn, .cmdValid(cv[3]), .cmdRead(cr[3]),
		.cmdAddr(ca[3]), .cmdData(cd[3]), .frameDrop(fd[3]), .peekAddr, .peekData(pd[3]));
	dcsp_port_assertions #(.NDEV(3)) dcsp_port_assertions_i (.ref_clk, .rstn,
		.sclk(t[0].sclk), .csN(t[0].csN), .sdi(t[0].sdi), .sdo(t[0].sdo));
	always @(posedge ref_clk) begin
		if (fd[0] === 1'b1 || fd[1] === 1'b1 || fd[2] === 1'b1 || fd[3] === 1'b1) nDrop++;
		if (cv[3] === 1'b1) nValid++;
		if (cv[0] === 1'b1 && cv[1] === 1'b1 && cv[2] === 1'b1) nChain++;
	end
	task automatic tallyAndFinish();
		if (errCount == 0 && numChecks > 0) $display("Finished cleanly");
		else $display("Finished with errors");
		$finish;
	endtask
	task automatic chk(input logic [47:0] got, input logic [47:0] exp);
		numChecks++;
		if (got !== exp) begin
			errCount++;
			$display("[FAIL] t=%0t got %h exp %h", $time, got, exp);
		end
	endtask
	task automatic xfer(input logic [47:0] tx);
		int n;
		n = 0;
		@(posedge ref_clk);
		#1 txBits = tx;
		start = 1'b1;
		@(posedge ref_clk);
		#1 start = 1'b0;
		while (done !== 1'b1) begin
			@(posedge ref_clk);
			#1 n++;
			if (n > 1000) begin
				errCount++;
				tallyAndFinish();
			end
		end
	endtask
	// hand-made frame of nb bits, msb first, sdo caught before each rise
	task automatic rogue(input logic [15:0] w, input int nb, output logic [15:0] q);
		r.csN = 1'b0;
		q = '0;
		#12;
		for (int i = 15; i > 15 - nb; i--) begin
			r.sdi = w[i];
			#6 q = {q[14:0], r.sdo};
			r.sclk = 1'b1;
			#6 r.sclk = 1'b0;
		end
		#6 r.csN = 1'b1;
		r.sdi = ~r.sdi;
		#300;
	endtask
	initial begin
		r.csN = 1'b1;
		r.sclk = 1'b0;
		r.sdi = 1'b0;
		rowTx[0] = 48'h0AA5_0C3C_0E81;
		rowTx[1] = 48'h0BFF_0DFF_0FFF;
		rowTx[2] = 48'h0A5A_0CC3_0E18;
		rowTx[3] = rowTx[1];
		rowTx[4] = 48'hFFFF_FFFF_FFFF;
		rowRx[0] = '0;
		rowRx[1] = '0;
		rowRx[2] = 48'h00A5_003C_0081;
		rowRx[3] = '0;
		rowRx[4] = 48'h005A_00C3_0018;
		repeat (2) @(posedge ref_clk);
		#1 rstn = 1'b1;
		chk({m.csN, m.sclk, busy, t[0].sdo}, 4'h8);
		for (int i = 0; i < 5; i++) begin
			xfer(rowTx[i]);
			chk(rxBits, rowRx[i]);
			chk({ca[0], cr[0], cd[0]}, rowTx[i][15:0]);
		end
		@(posedge ref_clk);
		#1 chk({pd[2], pd[1], pd[0]}, 24'h5A_0000);
		chk(nChain, 48'h5);
		peekAddr = 7'h09;
		repeat (8) begin
			#6 r.sclk = 1'b1;
			r.sdi = ~r.sdi;
			#6 r.sclk = 1'b0;
		end
		chk(r.sdo, 1'b0);
		rogue(16'h1277, 8, cap);
		chk({nDrop[3:0], nValid[3:0], pd[3]}, 16'h1000);
		rogue(16'h1277, 16, cap);
		chk({nValid[3:0], pd[3]}, 12'h177);
		rogue(16'h13FF, 16, cap);
		chk(cap, 16'h0000);
		rogue(16'hFFFF, 16, cap);
		chk(cap, 16'h0077);
		tallyAndFinish();
	end
endmodule // daisy_chain_spi_register_port_test
`default_nettype wire

//--- testbench/dcsp_port_assertions.sv
// Purpose: link checks on the first target
// Assumes: sclk made by the controller
// Notes: hist spans one frame, cnt the whole 16*NDEV-bit transfer
`timescale 1ns/1ps
`default_nettype none
module dcsp_port_assertions #(
	parameter int NDEV = 3
) (
	// clocks and reset
	input wire logic ref_clk,
	input wire logic rstn,
	input wire logic sclk,
	// link
	input wire logic csN,
	input wire logic sdi,
	input wire logic sdo
);
	logic [6:0] cnt;
	logic [15:0] hist;
	// rising edges in this frame
	always_ff @(posedge sclk or posedge csN) begin
		if (csN) begin
			cnt <= 7'h00;
		end else begin
			cnt <= cnt + 7'h01;
		end
	end
	always_ff @(posedge sclk) begin
		hist <= {hist[14:0], sdi};
	end
	property p_idle;
		@(posedge ref_clk) disable iff (!rstn) csN |-> !sdo;
	endproperty
	a_idle: assert property (p_idle) else $error("sdo high");
	property p_fall;
		@(posedge ref_clk) disable iff (!rstn) !csN && $changed(sdo) |-> !sclk;
	endproperty
	a_fall: assert property (p_fall) else $error("sdo moved");
	property p_hold;
		@(posedge ref_clk) disable iff (!rstn) sclk |-> $stable(sdo);
	endproperty
	a_hold: assert property (p_hold) else $error("sdo unstable");
	property p_pass;
		@(posedge sclk) disable iff (!rstn) cnt >= 7'h10 |-> sdo == hist[15];
	endproperty
	a_pass: assert property (p_pass) else $error("shift mismatch");
	property p_end;
		@(posedge ref_clk) disable iff (!rstn) $rose(csN) |-> !sclk;
	endproperty
	a_end: assert property (p_end) else $error("sclk high at end");
	property p_begin;
		@(posedge ref_clk) disable iff (!rstn) $fell(csN) |-> !sclk && !$past(sclk);
	endproperty
	a_begin: assert property (p_begin) else $error("not idle");
	property p_count;
		@(posedge ref_clk) disable iff (!rstn) $rose(csN) |-> $past(cnt) == 16 * NDEV;
	endproperty
	a_count: assert property (p_count) else $error("bit count");
	property p_sdi;
		@(posedge ref_clk) disable iff (!rstn) sclk |-> $stable(sdi);
	endproperty
	a_sdi: assert property (p_sdi) else $error("sdi moved");
endmodule // dcsp_port_assertions
`default_nettype wire
